// file: core/asc_pkg.sv
`default_nettype none
package asc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_RES_HI   = 8'h1e;
  localparam logic [7:0] IDX_CTRL     = 8'h1f;
  localparam logic [7:0] IDX_ANALOG_PIN_SELECT    = 8'h91;
  localparam logic [7:0] IDX_RES_LO   = 8'h9e;
  localparam logic [7:0] IDX_CLKCFG   = 8'h9f;
  localparam logic [7:0] IDX_INT_STAT = 8'ha0;
  localparam logic [7:0] IDX_INT_MASK = 8'ha1;

  // values after reset
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [7:0] ANALOG_PIN_SELECT_RST    = 8'hff;
  localparam logic [7:0] CLKCFG_RST   = 8'h00;
  localparam logic [7:0] MASK_RST     = 8'h00;

  // writable bits; the rest read as zero
  localparam logic [7:0] CTRL_WMASK   = 8'hdf;
  localparam logic [7:0] CLKCFG_WMASK = 8'h70;

  // field positions
  localparam int unsigned JUST_BIT = 7;
  localparam int unsigned VREF_BIT = 6;
  localparam int unsigned CHS_LSB  = 2;
  localparam int unsigned GO_BIT   = 1;
  localparam int unsigned EN_BIT   = 0;
  localparam int unsigned CS_LSB   = 4;
  localparam int unsigned DONE_BIT = 0;

  localparam logic [3:0]  CAPT_TRIG_MODE = 4'hb;
  localparam logic [12:0] WAKE_VECTOR    = 13'h0004;

  // cycle counts: instruction is 4 clocks, conversion 11 bit periods
  localparam logic [3:0] INSTR_LAST = 4'h3;
  localparam logic [3:0] CONV_LAST  = 4'ha;
  localparam logic [3:0] ABORT_LAST = 4'h1;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_CONV,
    ST_ABORT
  } asc_state_e;

  // high byte in [15:8], low byte in [7:0]
  function automatic logic [15:0] asc_justify(input logic [9:0] r,
                                              input logic       right);
    if (right) begin
      asc_justify = {6'h00, r};
    end else begin
      asc_justify = {r, 6'h00};
    end
  endfunction

endpackage
`default_nettype wire

// file: core/asc_tad_div.sv
`default_nettype none
module asc_tad_div (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [2:0] clk_sel_i,
  input  wire logic       rc_tick_i,
  output logic            tad_tick_o
);
  import asc_pkg::*;

  logic [5:0] cnt_ff;
  logic       tick_ff;

  // terminal count of the system clock divider
  function automatic logic [5:0] div_last(input logic [2:0] code);
    unique case (code)
      3'b000:  div_last = 6'd1;
      3'b001:  div_last = 6'd7;
      3'b010:  div_last = 6'd31;
      3'b100:  div_last = 6'd3;
      3'b101:  div_last = 6'd15;
      3'b110:  div_last = 6'd63;
      default: div_last = 6'd0;
    endcase
  endfunction

  wire logic rc_sel = (clk_sel_i[1:0] == 2'b11);

  // restart while idle so every bit period is whole
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i || rc_sel) begin
      cnt_ff <= 6'd0;
    end else if (cnt_ff == div_last(clk_sel_i)) begin
      cnt_ff <= 6'd0;
    end else begin
      cnt_ff <= cnt_ff + 6'd1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      tick_ff <= 1'b0;
    end else if (rc_sel) begin
      tick_ff <= rc_tick_i;
    end else begin
      tick_ff <= (cnt_ff == div_last(clk_sel_i));
    end
  end

  assign tad_tick_o = tick_ff;

endmodule // asc_tad_div
`default_nettype wire

// file: core/asc_top.sv
`default_nettype none
module asc_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        sleep_i,
  input  wire logic        global_int_enable_i,
  input  wire logic [3:0]  capture_mode_field_i,
  input  wire logic        special_trigger_i,
  input  wire logic        rc_osc_i,
  input  wire logic [9:0]  sample_i,
  output logic             conv_power_o,
  output logic             sample_hold_o,
  output logic      [2:0]  channel_o,
  output logic             vref_pin_o,
  output logic      [7:0]  analog_pin_select_o,
  output logic             event_timer_reset_o,
  output logic             wake_o,
  output logic             vector_jump_o,
  output logic      [12:0] wake_vector_o,
  output logic             irq_o
);
  import asc_pkg::*;

  logic [7:0]  ctrl_ff;
  logic        go_ff;
  logic [7:0]  analog_pin_select_ff;
  logic [7:0]  clkcfg_ff;
  logic [7:0]  res_hi_ff;
  logic [7:0]  res_lo_ff;
  logic        stat_ff;
  logic        mask_ff;
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic        powered_ff;
  logic        rc_s1_ff;
  logic        rc_s2_ff;
  logic        rc_s3_ff;
  logic [9:0]  samp_s1_ff;
  logic [9:0]  samp_s2_ff;
  logic [3:0]  cnt_ff;
  logic        timer_rst_ff;
  logic        wake_ff;
  logic        jump_ff;
  logic [12:0] vec_ff;
  logic        tad_tick;
  logic [7:0]  rd_byte;
  asc_state_e  state_ff;

  wire logic [7:0] idx = adr_i[9:2];
  wire logic wr = cyc_i && stb_i && we_i && ack_ff && sel_i[0];
  wire logic wr_ctrl   = wr && (idx == IDX_CTRL);
  wire logic wr_analog_pin_select  = wr && (idx == IDX_ANALOG_PIN_SELECT);
  wire logic wr_clkcfg = wr && (idx == IDX_CLKCFG);
  wire logic wr_stat   = wr && (idx == IDX_INT_STAT);
  wire logic wr_mask   = wr && (idx == IDX_INT_MASK);

  wire logic en     = ctrl_ff[EN_BIT];
  wire logic rc_sel = (clkcfg_ff[CS_LSB +: 2] == 2'b11);
  wire logic trig_hit = special_trigger_i &&
                        (capture_mode_field_i == CAPT_TRIG_MODE);
  wire logic trig_start = trig_hit && en;
  wire logic sw_start   = wr_ctrl && dat_i[GO_BIT] && en;
  wire logic sw_abort   = wr_ctrl && !dat_i[GO_BIT];
  wire logic go_start   = (state_ff == ST_IDLE) && powered_ff &&
                          (sw_start || trig_start);
  // any clock but RC is unusable once the core sleeps
  wire logic sleep_abort = sleep_i && !rc_sel;
  wire logic kill = sleep_abort || !en;
  wire logic done_evt = (state_ff == ST_CONV) && tad_tick &&
                        (cnt_ff == CONV_LAST) && !kill && !sw_abort;
  wire logic shutdown = sleep_i && powered_ff &&
                        (sleep_abort || (done_evt && !mask_ff));

  // rc edges and the analog code come from outside this clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rc_s1_ff <= 1'b0;
      rc_s2_ff <= 1'b0;
      rc_s3_ff <= 1'b0;
    end else begin
      rc_s1_ff <= rc_osc_i;
      rc_s2_ff <= rc_s1_ff;
      rc_s3_ff <= rc_s2_ff;
    end
  end

  // code is only taken at the final bit period, long settled
  always_ff @(posedge clk_i) begin
    samp_s1_ff <= sample_i;
    samp_s2_ff <= samp_s1_ff;
  end

  asc_tad_div u_tad_div (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .run_i      ((state_ff == ST_CONV) || (state_ff == ST_ABORT)),
    .clk_sel_i  (clkcfg_ff[CS_LSB +: 3]),
    .rc_tick_i  (rc_s2_ff && !rc_s3_ff),
    .tad_tick_o (tad_tick)
  );

  // bus slave: ack one cycle after request, write at ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= cyc_i && stb_i && !ack_ff;
      if (cyc_i && stb_i && !ack_ff) begin
        dat_ff <= {24'h00_0000, rd_byte};
      end
    end
  end

  always_comb begin
    unique case (idx)
      IDX_RES_HI:   rd_byte = res_hi_ff;
      IDX_CTRL:     rd_byte = {ctrl_ff[7:2], go_ff, ctrl_ff[0]};
      IDX_ANALOG_PIN_SELECT:    rd_byte = analog_pin_select_ff;
      IDX_RES_LO:   rd_byte = res_lo_ff;
      IDX_CLKCFG:   rd_byte = clkcfg_ff;
      IDX_INT_STAT: rd_byte = {7'h00, stat_ff};
      IDX_INT_MASK: rd_byte = {7'h00, mask_ff};
      default:      rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff   <= CTRL_RST;
      analog_pin_select_ff  <= ANALOG_PIN_SELECT_RST;
      clkcfg_ff <= CLKCFG_RST;
      mask_ff   <= MASK_RST[DONE_BIT];
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= dat_i[7:0] & CTRL_WMASK & ~(8'h01 << GO_BIT);
      end
      if (wr_analog_pin_select) begin
        analog_pin_select_ff <= dat_i[7:0];
      end
      if (wr_clkcfg) begin
        clkcfg_ff <= dat_i[7:0] & CLKCFG_WMASK;
      end
      if (wr_mask) begin
        mask_ff <= dat_i[DONE_BIT];
      end
    end
  end

  // sleep power-down leaves the enable bit set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      powered_ff <= 1'b0;
    end else if (shutdown) begin
      powered_ff <= 1'b0;
    end else if (!sleep_i) begin
      powered_ff <= en;
    end
  end

  // busy flag: completion, sleep and disable aborts win over a start; a software abort loses to a trigger start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      go_ff <= 1'b0;
    end else if (done_evt || kill) begin
      go_ff <= 1'b0;
    end else if (go_start) begin
      go_ff <= 1'b1;
    end else if (sw_abort && state_ff != ST_DELAY) begin
      go_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 4'h0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          cnt_ff <= 4'h0;
          if (go_start) begin
            // RC: let a sleep instruction run first
            state_ff <= rc_sel ? ST_DELAY : ST_CONV;
          end
        end
        ST_DELAY: begin
          if (!en) begin
            state_ff <= ST_IDLE;
          end else if (cnt_ff == INSTR_LAST) begin
            state_ff <= ST_CONV;
            cnt_ff   <= 4'h0;
          end else begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
        ST_CONV: begin
          if (kill) begin
            state_ff <= ST_IDLE;
          end else if (sw_abort) begin
            state_ff <= ST_ABORT;
            cnt_ff   <= 4'h0;
          end else if (done_evt) begin
            state_ff <= ST_IDLE;
          end else if (tad_tick) begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
        ST_ABORT: begin
          if (kill || (tad_tick && cnt_ff == ABORT_LAST)) begin
            state_ff <= ST_IDLE;
          end else if (tad_tick) begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
      endcase
    end
  end

  // no reset: the result pair survives a device reset
  always_ff @(posedge clk_i) begin
    if (done_evt) begin
      {res_hi_ff, res_lo_ff} <= asc_justify(samp_s2_ff,
                                            ctrl_ff[JUST_BIT]);
    end
  end

  // done flag: a completion in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_ff <= 1'b0;
    end else begin
      stat_ff <= (stat_ff && !(wr_stat && dat_i[DONE_BIT])) ||
                 done_evt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_rst_ff <= 1'b0;
      wake_ff      <= 1'b0;
      jump_ff      <= 1'b0;
      vec_ff       <= 13'h0000;
    end else begin
      timer_rst_ff <= trig_hit;
      wake_ff <= done_evt && sleep_i && mask_ff;
      jump_ff <= done_evt && sleep_i && mask_ff &&
                 global_int_enable_i;
      vec_ff  <= (done_evt && sleep_i && mask_ff &&
                  global_int_enable_i) ? WAKE_VECTOR : 13'h0000;
    end
  end

  assign ack_o               = ack_ff;
  assign dat_o               = dat_ff;
  assign conv_power_o        = powered_ff && en;
  assign sample_hold_o       = powered_ff && en && state_ff == ST_IDLE;
  assign channel_o           = ctrl_ff[CHS_LSB +: 3];
  assign vref_pin_o          = ctrl_ff[VREF_BIT];
  assign analog_pin_select_o = analog_pin_select_ff;
  assign event_timer_reset_o = timer_rst_ff;
  assign wake_o              = wake_ff;
  assign vector_jump_o       = jump_ff;
  assign wake_vector_o       = vec_ff;
  assign irq_o               = stat_ff && mask_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_rc_sleep_keep: assert property (
    (state_ff == ST_CONV) && rc_sel && sleep_i && en && !done_evt &&
    !wr_ctrl |=> go_ff && state_ff == ST_CONV)
    else $error("rc conversion stopped in sleep");

  a_rc_start_delay: assert property (
    go_start && rc_sel
    |=> (state_ff == ST_DELAY)[*4])
    else $error("rc start not delayed one instruction");

  a_done_result: assert property (
    done_evt |=> {res_hi_ff, res_lo_ff} ==
      asc_justify($past(samp_s2_ff), $past(ctrl_ff[JUST_BIT])))
    else $error("result not loaded in chosen format");

  a_done_flags: assert property (
    done_evt |=> !go_ff && stat_ff && state_ff == ST_IDLE)
    else $error("completion flags wrong");

  a_sleep_wake: assert property (
    done_evt && sleep_i && mask_ff
    |=> wake_o && (vector_jump_o == $past(global_int_enable_i)))
    else $error("no wake on sleep completion");

  a_sleep_powerdown: assert property (
    done_evt && sleep_i && !mask_ff && !wr_ctrl
    |=> !conv_power_o && ctrl_ff[EN_BIT] && !wake_o)
    else $error("no power down after silent completion");

  a_nonrc_abort: assert property (
    sleep_i && !rc_sel && en && state_ff != ST_IDLE && !wr_ctrl
    |=> state_ff == ST_IDLE && !go_ff && !conv_power_o &&
        ctrl_ff[EN_BIT])
    else $error("sleep did not abort conversion");

  a_reset_state: assert property (
    $fell(rst_i) |-> ctrl_ff == CTRL_RST && !go_ff &&
      !conv_power_o && state_ff == ST_IDLE && clkcfg_ff == CLKCFG_RST)
    else $error("reset values wrong");

  a_trig_start: assert property (
    trig_hit && en && powered_ff && state_ff == ST_IDLE && !wr_ctrl
    |=> go_ff && event_timer_reset_o)
    else $error("trigger did not start conversion");

  a_trig_ignored: assert property (
    trig_hit && !en |=> !go_ff && event_timer_reset_o)
    else $error("disabled trigger handled wrongly");

  a_sw_abort: assert property (
    state_ff == ST_CONV && sw_abort && !kill
    |=> state_ff == ST_ABORT && !go_ff ##1 $stable(res_hi_ff))
    else $error("software abort handled wrongly");

  c_plain_conv: cover property (done_evt && !sleep_i);
  c_sleep_wake: cover property (done_evt && sleep_i && mask_ff);
  c_trig_conv:  cover property (trig_start && go_start);
  c_abort_wait: cover property (state_ff == ST_ABORT && tad_tick);

endmodule // asc_top
`default_nettype wire

// file: bench/asc_analog_model.sv
`default_nettype none
module asc_analog_model (
  input  wire logic [9:0] code_i,
  output logic            rc_osc_o,
  output logic [9:0]      sample_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // free-running oscillator, period off the bus clock grid on purpose
  // one process owns the pin, so it has a single driver
  initial begin
    rc_osc_o = 1'b0;
    forever #1003 rc_osc_o = ~rc_osc_o;
  end

  // code lags the input a little, like a real comparator chain
  assign #7 sample_o = code_i;
endmodule // asc_analog_model
`default_nettype wire

// file: bench/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import asc_pkg::*;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic        slp   = 1'b0;
  logic        global_int_enable   = 1'b0;
  logic        trg   = 1'b0;
  logic [3:0]  mode  = 4'h0;
  logic [9:0]  adr   = 10'h000;
  logic [9:0]  code  = 10'h000;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] dat_o;
  logic [9:0]  smp;
  logic [12:0] wvec;
  logic        ack_o, rc, pwr, shold, etr, wake, vj, irq;
  logic [7:0]  q, hi_ff, lo_ff;
  logic [7:0]  apsel;
  logic [2:0]  chan;
  logic        vref;
  logic [2:0]  cl [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  int          errors = 0;
  int          num_checks = 0;

  always #50 clk_i = ~clk_i;

  asc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(dat_o),
    .ack_o(ack_o), .sleep_i(slp), .global_int_enable_i(global_int_enable),
    .capture_mode_field_i(mode), .special_trigger_i(trg), .rc_osc_i(rc),
    .sample_i(smp), .conv_power_o(pwr), .sample_hold_o(shold),
    .channel_o(chan), .vref_pin_o(vref), .analog_pin_select_o(apsel),
    .event_timer_reset_o(etr), .wake_o(wake), .vector_jump_o(vj),
    .wake_vector_o(wvec), .irq_o(irq));

  asc_analog_model PM (.code_i(code), .rc_osc_o(rc), .sample_o(smp));

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // one classic cycle; read data lands in q at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {a, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      print_verdict();
    end
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk({8'h00, q}, {8'h00, e});
  endtask

  // 0: acquiring again, 1: wake pulse, 2: analog powered down
  task automatic waitfor(input int s, output int n);
    n = 0;
    while (n < 3000) begin
      @(posedge clk_i);
      n++;
      if ((s == 0 && shold === 1'b1) || (s == 1 && wake === 1'b1) ||
          (s == 2 && pwr === 1'b0)) break;
    end
    if (n >= 3000) begin
      errors++;
      print_verdict();
    end
  endtask

  task automatic t_regs;
    rdc(IDX_CTRL, CTRL_RST);
    rdc(IDX_ANALOG_PIN_SELECT, ANALOG_PIN_SELECT_RST);
    rdc(IDX_CLKCFG, CLKCFG_RST);
    rdc(IDX_INT_MASK, MASK_RST);
    wb(1'b1, IDX_CLKCFG, 8'hff);
    rdc(IDX_CLKCFG, 8'h70);
    wb(1'b1, 8'h40, 8'hff);
    rdc(8'h40, 8'h00);
    wb(1'b1, IDX_ANALOG_PIN_SELECT, 8'h5a);
    rdc(IDX_ANALOG_PIN_SELECT, 8'h5a);
    chk({8'h00, apsel}, 16'h005a);
    wb(1'b1, IDX_CTRL, 8'h5c);
    chk({12'h000, vref, chan}, 16'h000f);
    rdc(IDX_CTRL, 8'h5c);
    wb(1'b1, IDX_CTRL, 8'h00);
    $display("t_regs done");
  endtask

  task automatic t_conv(input logic [2:0] cs, input logic j,
                        input logic [9:0] c);
    int n, d;
    d = (cs == 3'h0) ? 2 : (cs == 3'h1) ? 8 : (cs == 3'h2) ? 32 :
        (cs == 3'h4) ? 4 : (cs == 3'h5) ? 16 : 64;
    code <= c;
    wb(1'b1, IDX_INT_MASK, 8'h01);
    wb(1'b1, IDX_CLKCFG, {1'b0, cs, 4'h0});
    wb(1'b1, IDX_CTRL, {j, 7'h01});
    repeat (200) @(posedge clk_i);
    wb(1'b1, IDX_CTRL, {j, 7'h03});
    waitfor(0, n);
    chk(16'(n >= 11 * d - 4 && n <= 12 * d + 8), 16'h1);
    hi_ff = j ? {6'h0, c[9:8]} : c[9:2];
    lo_ff = j ? c[7:0] : {c[1:0], 6'h0};
    rdc(IDX_RES_HI, hi_ff);
    rdc(IDX_RES_LO, lo_ff);
    rdc(IDX_CTRL, {j, 7'h01});
    rdc(IDX_INT_STAT, 8'h01);
    chk({15'h0, irq}, 16'h1);
    wb(1'b1, IDX_INT_STAT, 8'h01);
    chk({15'h0, irq}, 16'h0);
    $display("t_conv done code %h", cs);
  endtask

  task automatic t_abort;
    int n;
    code <= ~code;
    wb(1'b1, IDX_CTRL, 8'h83);
    repeat (100) @(posedge clk_i);
    wb(1'b1, IDX_CTRL, 8'h81);
    waitfor(0, n);
    chk(16'(n >= 64 && n <= 200), 16'h1);
    rdc(IDX_RES_HI, hi_ff);
    rdc(IDX_RES_LO, lo_ff);
    rdc(IDX_INT_STAT, 8'h00);
    $display("t_abort done");
  endtask

  task automatic pulse(output logic e, output logic s);
    trg <= 1'b1;
    @(posedge clk_i);
    trg <= 1'b0;
    @(posedge clk_i);
    e = etr;
    s = shold;
  endtask

  task automatic t_trig;
    int n;
    logic e, s;
    wb(1'b1, IDX_CLKCFG, 8'h00);
    wb(1'b1, IDX_CTRL, 8'h01);
    repeat (200) @(posedge clk_i);
    mode <= CAPT_TRIG_MODE;
    pulse(e, s);
    chk({14'h0, e, s}, 16'h2);
    waitfor(0, n);
    rdc(IDX_INT_STAT, 8'h01);
    wb(1'b1, IDX_INT_STAT, 8'h01);
    mode <= 4'ha;
    pulse(e, s);
    chk({14'h0, e, s}, 16'h1);
    mode <= CAPT_TRIG_MODE;
    wb(1'b1, IDX_CTRL, 8'h00);
    pulse(e, s);
    chk({15'h0, e}, 16'h1);
    rdc(IDX_CTRL, 8'h00);
    $display("t_trig done");
  endtask

  task automatic t_sleep_fast;
    wb(1'b1, IDX_CLKCFG, 8'h60);
    wb(1'b1, IDX_CTRL, 8'h01);
    wb(1'b1, IDX_CTRL, 8'h03);
    repeat (10) @(posedge clk_i);
    slp <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({15'h0, pwr}, 16'h0);
    rdc(IDX_CTRL, 8'h01);
    rdc(IDX_INT_STAT, 8'h00);
    slp <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({15'h0, pwr}, 16'h1);
    $display("t_sleep_fast done");
  endtask

  task automatic t_sleep_rc(input logic m, input logic g);
    int n;
    code <= {m, g, 8'h3c};
    global_int_enable <= g;
    wb(1'b1, IDX_INT_MASK, {7'h0, m});
    wb(1'b1, IDX_CLKCFG, 8'h30);
    wb(1'b1, IDX_CTRL, 8'h81);
    repeat (200) @(posedge clk_i);
    wb(1'b1, IDX_CTRL, 8'h83);
    // sleep lands inside the start delay, as software would do
    slp <= 1'b1;
    waitfor(m ? 1 : 2, n);
    if (m) begin
      chk({2'h0, vj, wvec}, {2'h0, g, g ? WAKE_VECTOR : 13'h0});
    end
    rdc(IDX_CTRL, 8'h81);
    hi_ff = {6'h0, m, g};
    lo_ff = 8'h3c;
    rdc(IDX_RES_HI, hi_ff);
    rdc(IDX_RES_LO, lo_ff);
    rdc(IDX_INT_STAT, 8'h01);
    wb(1'b1, IDX_INT_STAT, 8'h01);
    slp <= 1'b0;
    global_int_enable <= 1'b0;
    $display("t_sleep_rc done %b%b", m, g);
  endtask

  task automatic t_rst;
    wb(1'b1, IDX_CLKCFG, 8'h60);
    wb(1'b1, IDX_CTRL, 8'h01);
    wb(1'b1, IDX_CTRL, 8'h03);
    code <= 10'h0ff;
    repeat (50) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({15'h0, pwr}, 16'h0);
    rdc(IDX_CTRL, CTRL_RST);
    rdc(IDX_ANALOG_PIN_SELECT, ANALOG_PIN_SELECT_RST);
    rdc(IDX_RES_HI, hi_ff);
    rdc(IDX_RES_LO, lo_ff);
    $display("t_rst done");
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    for (int i = 0; i < 6; i++) begin
      t_conv(cl[i], 1'(i), 10'h2d5 + 10'(i));
    end
    t_abort();
    t_trig();
    t_sleep_fast();
    t_sleep_rc(1'b1, 1'b1);
    t_sleep_rc(1'b1, 1'b0);
    t_sleep_rc(1'b0, 1'b0);
    t_rst();
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
